// ### src/edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
// edge finder for a sampled clock input, one-cycle pulses
module edge_detect (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic sig_in,
   output logic      rise,
   output logic      fall
);
   logic prev_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= sig_in;
      end
   end

   assign rise = sig_in & ~prev_reg;
   assign fall = ~sig_in & prev_reg;
endmodule : edge_detect
`default_nettype wire

// ### src/osc_startup.sv
`timescale 1ns/1ps
`default_nettype none
module osc_startup #(
   parameter int SETTLE_COUNT = osc_startup_pkg::SETTLE_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // configuration and system events
   input  wire logic [2:0]  cfg_oscillator_select,
   input  wire logic        cfg_multiplier_enable,
   input  wire logic        cfg_two_speed_enable,
   input  wire logic        power_up_delay_enable,
   input  wire logic        power_up_delay_done,
   input  wire logic        sleep_enter,
   input  wire logic        wake_from_sleep,
   // clock inputs, sampled
   input  wire logic        external_osc_input,
   input  wire logic        internal_osc_input,
   // clock control outputs
   output logic             sysclk_gate_low,
   output logic             sysclk_select_ext,
   output logic             multiplier_enable,
   output logic [3:0]       internal_freq_out,
   output logic             core_halt
);
   initial begin
      if (SETTLE_COUNT < 1) $error("settle count must be positive");
   end

   // ****************************************************************
   // state
   // ****************************************************************
   typedef enum logic [2:0] {
      st_idle, st_wait_por, st_count, st_wait_int_fall, st_hold_low, st_ext, st_sleep
   } seq_t;

   typedef struct packed {
      seq_t                    seq;
      osc_startup_pkg::osc_ctrl_t ctrl;
      logic                    ext_running;
      logic                    halt;
      logic                    gate_low;
      logic                    sel_ext;
      logic                    mult_en;
      logic [31:0]             rdata;
      logic                    ready;
      logic                    slverr;
   } state_t;

   state_t s_reg;
   state_t s_next;

   logic ext_rise, ext_fall, int_fall;
   logic cnt_done;
   logic cnt_clear;
   logic cnt_run;
   logic crystal;
   logic launch;

   edge_detect u_ext_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .sig_in  (external_osc_input),
      .rise    (ext_rise),
      .fall    (ext_fall)
   );

   edge_detect u_int_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .sig_in  (internal_osc_input),
      .rise    (),
      .fall    (int_fall)
   );

   settle_counter #(.COUNT(SETTLE_COUNT)) u_settle (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (cnt_clear),
      .run     (cnt_run),
      .tick    (ext_rise),
      .done    (cnt_done)
   );

   assign crystal   = osc_startup_pkg::is_crystal_mode(cfg_oscillator_select);
   // power-up delay, when enabled, gates every launch from st_wait_por, including the one after wake
   assign launch    = !power_up_delay_enable || power_up_delay_done;
   assign cnt_clear = (s_reg.seq == st_idle) || (s_reg.seq == st_wait_por) ||
                      (s_reg.seq == st_sleep) || sleep_enter;
   assign cnt_run   = (s_reg.seq == st_count);

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic wr;
      logic rd;
      logic two_speed;
      wr = psel && penable && pwrite;
      rd = psel && !penable && !pwrite;
      two_speed = cfg_two_speed_enable || s_reg.ctrl.two_speed_enable;
      s_next = s_reg;
      s_next.ready  = 1'b1;
      s_next.slverr = 1'b0;

      case (s_reg.seq)
         st_idle: begin
            s_next.seq = st_wait_por;
         end
         st_wait_por: begin
            if (launch) begin
               if (crystal) begin
                  s_next.seq  = st_count;
                  s_next.halt = !two_speed;
               end else begin
                  s_next.seq  = st_ext;
                  s_next.halt = 1'b0;
               end
            end
         end
         st_count: begin
            if (cnt_done) begin
               s_next.seq = st_wait_int_fall;
            end
         end
         st_wait_int_fall: begin
            if (int_fall) begin
               s_next.ext_running = 1'b1;
               s_next.gate_low    = 1'b1;
               s_next.seq         = st_hold_low;
            end
         end
         st_hold_low: begin
            if (ext_fall) begin
               s_next.gate_low = 1'b0;
               s_next.sel_ext  = 1'b1;
               s_next.halt     = 1'b0;
               s_next.seq      = st_ext;
            end
         end
         st_ext: begin
         end
         st_sleep: begin
            if (wake_from_sleep) begin
               s_next.seq = st_wait_por;
            end
         end
         default: begin
            s_next.seq = st_idle;
         end
      endcase

      // sleep drops back to the internal clock so the next start-up begins clean
      if (sleep_enter) begin
         s_next.seq         = st_sleep;
         s_next.ext_running = 1'b0;
         s_next.sel_ext     = 1'b0;
         s_next.gate_low    = 1'b0;
         s_next.halt        = 1'b0;
      end

      // either the config bit or the software bit enables the multiplier
      s_next.mult_en = cfg_multiplier_enable || s_reg.ctrl.sw_multiplier_enable;

      if (wr && paddr == osc_startup_pkg::OSC_CONTROL_OFFSET) begin
         s_next.ctrl.sw_multiplier_enable = pwdata[osc_startup_pkg::SW_MULT_EN_BIT];
         s_next.ctrl.internal_freq_select =
            pwdata[osc_startup_pkg::FREQ_SEL_LSB +: osc_startup_pkg::FREQ_SEL_W];
         s_next.ctrl.two_speed_enable = pwdata[osc_startup_pkg::TWO_SPEED_EN_BIT];
      end
      if (psel && penable) begin
         s_next.slverr = (paddr != osc_startup_pkg::OSC_CONTROL_OFFSET) &&
                         (paddr != osc_startup_pkg::OSC_STATUS_OFFSET);
      end

      if (rd) begin
         s_next.rdata = 32'h0000_0000;
         if (paddr == osc_startup_pkg::OSC_CONTROL_OFFSET) begin
            s_next.rdata[osc_startup_pkg::SW_MULT_EN_BIT]   = s_reg.ctrl.sw_multiplier_enable;
            s_next.rdata[osc_startup_pkg::FREQ_SEL_LSB +: osc_startup_pkg::FREQ_SEL_W] =
               s_reg.ctrl.internal_freq_select;
            s_next.rdata[osc_startup_pkg::TWO_SPEED_EN_BIT] = s_reg.ctrl.two_speed_enable;
         end else if (paddr == osc_startup_pkg::OSC_STATUS_OFFSET) begin
            s_next.rdata[osc_startup_pkg::EXT_RUNNING_BIT] = s_reg.ext_running;
            s_next.rdata[osc_startup_pkg::MULT_ACTIVE_BIT] = s_reg.mult_en;
            s_next.rdata[osc_startup_pkg::SETTLE_DONE_BIT] = cnt_done;
            s_next.rdata[osc_startup_pkg::CORE_HALT_BIT]   = s_reg.halt;
         end
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg.seq         <= st_idle;
         s_reg.ctrl        <= osc_startup_pkg::osc_ctrl_t'({
                                 osc_startup_pkg::CONTROL_RESET[7],
                                 osc_startup_pkg::CONTROL_RESET[6:3],
                                 osc_startup_pkg::CONTROL_RESET[0]});
         s_reg.ext_running <= 1'b0;
         s_reg.halt        <= 1'b0;
         s_reg.gate_low    <= 1'b0;
         s_reg.sel_ext     <= 1'b0;
         s_reg.mult_en     <= 1'b0;
         s_reg.rdata       <= 32'h0000_0000;
         s_reg.ready       <= 1'b0;
         s_reg.slverr      <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata            = s_reg.rdata;
   assign pready            = s_reg.ready;
   assign pslverr           = s_reg.slverr;
   assign sysclk_gate_low   = s_reg.gate_low;
   assign sysclk_select_ext = s_reg.sel_ext;
   assign multiplier_enable = s_reg.mult_en;
   assign internal_freq_out = s_reg.ctrl.internal_freq_select;
   assign core_halt         = s_reg.halt;
endmodule : osc_startup
`default_nettype wire

// ### src/osc_startup_pkg.sv
package osc_startup_pkg;

   // ****************************************************************
   // register map (byte addresses on the apb bus)
   // ****************************************************************
   localparam logic [7:0] OSC_CONTROL_OFFSET = 8'h00;
   localparam logic [7:0] OSC_STATUS_OFFSET  = 8'h04;

   // control register fields
   localparam int SW_MULT_EN_BIT   = 7;
   localparam int FREQ_SEL_LSB     = 3;
   localparam int FREQ_SEL_W       = 4;
   localparam int TWO_SPEED_EN_BIT = 0;
   localparam logic [31:0] CONTROL_RESET  = 32'h0000_0038;
   localparam logic [31:0] CONTROL_WMASK  = 32'h0000_00f9;

   // status register fields
   localparam int EXT_RUNNING_BIT  = 0;
   localparam int MULT_ACTIVE_BIT  = 1;
   localparam int SETTLE_DONE_BIT  = 2;
   localparam int CORE_HALT_BIT    = 3;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int SETTLE_CYCLES    = 1024;
   localparam int MULT_FACTOR      = 4;

   // oscillator select encodings
   typedef enum logic [2:0] {
      low_power_crystal_mode  = 3'h0,
      crystal_mode            = 3'h1,
      high_speed_crystal_mode = 3'h2,
      external_clock_mode     = 3'h3,
      internal_osc_mode       = 3'h4
   } osc_mode_t;

   typedef struct packed {
      logic       sw_multiplier_enable;
      logic [3:0] internal_freq_select;
      logic       two_speed_enable;
   } osc_ctrl_t;

   function automatic logic is_crystal_mode(input logic [2:0] mode);
      return (mode == low_power_crystal_mode) || (mode == crystal_mode) ||
             (mode == high_speed_crystal_mode);
   endfunction : is_crystal_mode

endpackage : osc_startup_pkg

// ### src/settle_counter.sv
`timescale 1ns/1ps
`default_nettype none
// counts external oscillator rising edges up to a stability threshold
module settle_counter #(
   parameter int COUNT = osc_startup_pkg::SETTLE_CYCLES
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clear,
   input  wire logic run,
   input  wire logic tick,
   output logic      done
);
   localparam int W = $clog2(COUNT + 1);
   logic [W-1:0] cnt_reg;

   initial begin
      if (COUNT < 1) $error("settle count must be positive");
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
      end else if (clear) begin
         cnt_reg <= '0;
      end else if (run && tick && !done) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   assign done = (cnt_reg == W'(COUNT));
endmodule : settle_counter
`default_nettype wire

// ### tb/osc_startup_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module osc_startup_assertions #(
   parameter int SETTLE_COUNT = 1024
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pslverr,
   input wire logic [2:0] cfg_oscillator_select,
   input wire logic       cfg_multiplier_enable,
   input wire logic       sleep_enter,
   input wire logic       external_osc_input,
   input wire logic       sysclk_gate_low,
   input wire logic       sysclk_select_ext,
   input wire logic       multiplier_enable,
   input wire logic       core_halt
);
   logic        ext_q;
   int unsigned rises;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // counts every rising edge since reset or sleep, so it never lags the design's settle count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_q <= 1'b0;
         rises <= 0;
      end else begin
         ext_q <= external_osc_input;
         if (sleep_enter) rises <= 0;
         else if (external_osc_input && !ext_q) rises <= rises + 1;
      end
   end
   sequence s_gate_start; $rose(sysclk_gate_low); endsequence
   sequence s_on_ext; !sysclk_gate_low && sysclk_select_ext; endsequence
   a_settle_count: assert property (s_gate_start |-> rises >= SETTLE_COUNT)
      else $error("clock gated before the settle count");
   a_gate_then_ext: assert property (s_gate_start |-> ##[1:30] s_on_ext)
      else $error("no switch after the gate low phase");
   a_ext_after_gate: assert property ($rose(sysclk_select_ext) |-> $past(sysclk_gate_low) && !core_halt)
      else $error("switch without gate low phase");
   a_halt_internal: assert property (core_halt |-> !sysclk_select_ext)
      else $error("halt while on external clock");
   a_mult_cfg: assert property (cfg_multiplier_enable [*2] |-> multiplier_enable)
      else $error("multiplier off with config bit set");
   a_no_switch: assert property (cfg_oscillator_select > 3'h2 |-> !$rose(sysclk_select_ext))
      else $error("switch in a non crystal mode");
   a_sleep_clear: assert property (sleep_enter |=> ##[0:1] !sysclk_select_ext && !sysclk_gate_low)
      else $error("sleep entry left the source switched");
   a_bad_addr: assert property (psel && penable && paddr != 8'h00 && paddr != 8'h04 |=> pslverr)
      else $error("unmapped address without error");
endmodule : osc_startup_assertions
bind osc_startup osc_startup_assertions #(.SETTLE_COUNT(SETTLE_COUNT)) osc_startup_assertions_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pslverr(pslverr), .cfg_oscillator_select(cfg_oscillator_select),
   .cfg_multiplier_enable(cfg_multiplier_enable), .sleep_enter(sleep_enter),
   .external_osc_input(external_osc_input), .sysclk_gate_low(sysclk_gate_low),
   .sysclk_select_ext(sysclk_select_ext), .multiplier_enable(multiplier_enable),
   .core_halt(core_halt));
`default_nettype wire

// ### tb/osc_startup_test.sv
`timescale 1ns/1ps
`default_nettype none
module osc_startup_test;
   localparam int SETTLE = 8;
   localparam logic [7:0] CTRL = osc_startup_pkg::OSC_CONTROL_OFFSET;
   localparam logic [7:0] STAT = osc_startup_pkg::OSC_STATUS_OFFSET;
   logic pclk, pready, pslverr, ext_osc, gate_low, sel_ext, mult_en, core_halt;
   logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mult_cfg = 1'b0;
   logic pud_done = 1'b0, sleep_enter = 1'b0, wake = 1'b0, xtal_run = 1'b0, int_osc = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0]  osc_sel = 3'h1;
   logic [3:0]  freq_out;
   int num_errors = 0;
   int samples_checked = 0;
   int div = 0;
   xtal_model #(.HALF(5)) xtal_model_i (.pclk(pclk), .run(xtal_run), .osc_out(ext_osc));
   osc_startup #(.SETTLE_COUNT(SETTLE)) osc_startup_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_oscillator_select(osc_sel), .cfg_multiplier_enable(mult_cfg),
      .cfg_two_speed_enable(1'b0), .power_up_delay_enable(1'b1),
      .power_up_delay_done(pud_done), .sleep_enter(sleep_enter), .wake_from_sleep(wake),
      .external_osc_input(ext_osc), .internal_osc_input(int_osc), .sysclk_gate_low(gate_low),
      .sysclk_select_ext(sel_ext), .multiplier_enable(mult_en), .internal_freq_out(freq_out),
      .core_halt(core_halt));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // internal oscillator free runs at pclk/6
   always @(posedge pclk) begin
      div <= (div == 2) ? 0 : div + 1;
      if (div == 2) int_osc <= ~int_osc;
   end
   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         num_errors++;
         report_and_stop();
      end
   endtask : apb
   task automatic wait_switch(output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sel_ext !== 1'b1 && n < 400);
      if (sel_ext !== 1'b1) begin
         num_errors++;
         report_and_stop();
      end
   endtask : wait_switch
   task automatic sleep_wake(input logic [2:0] mode);
      @(posedge pclk);
      sleep_enter <= 1'b1;
      xtal_run <= 1'b0;
      @(posedge pclk);
      sleep_enter <= 1'b0;
      repeat (3) @(posedge pclk);
      check(32'(sel_ext), 32'h0);
      apb(1'b0, STAT, 32'h0);
      check(rd & 32'h1, 32'h0);
      osc_sel <= mode;
      xtal_run <= 1'b1;
      wake <= 1'b1;
      @(posedge pclk);
      wake <= 1'b0;
   endtask : sleep_wake
   task automatic test_registers_and_multiplier;
      apb(1'b0, CTRL, 32'h0);
      check(rd, osc_startup_pkg::CONTROL_RESET);
      apb(1'b1, CTRL, 32'hffff_ffff);
      apb(1'b0, CTRL, 32'h0);
      #1;
      check(32'(pslverr), 32'h0);
      check(rd, osc_startup_pkg::CONTROL_WMASK);
      check(32'(freq_out), 32'hf);
      check(32'(mult_en), 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0);
      // error flag is registered at the access edge, look once it has settled
      #1;
      check(32'(pslverr), 32'h1);
      mult_cfg <= 1'b1;
      apb(1'b1, CTRL, 32'h0000_0038);
      repeat (2) @(posedge pclk);
      check(32'(mult_en), 32'h1);
      mult_cfg <= 1'b0;
      repeat (2) @(posedge pclk);
      check(32'(mult_en), 32'h0);
   endtask : test_registers_and_multiplier
   task automatic test_startup(input logic two_speed);
      int n;
      apb(1'b1, CTRL, {31'h0000_001c, two_speed});
      if (two_speed) sleep_wake(3'h1);
      pud_done <= 1'b1;
      xtal_run <= 1'b1;
      repeat (3) @(posedge pclk);
      check(32'(core_halt), 32'(!two_speed));
      check(32'(freq_out), 32'h7);
      wait_switch(n);
      // 8th rising edge of a 10-cycle crystal lands 75 cycles after start
      check(32'(n + 3 >= 5 + (SETTLE - 1) * 10), 32'h1);
      check(32'(core_halt), 32'h0);
      check(32'(gate_low), 32'h0);
      apb(1'b0, STAT, 32'h0);
      check(rd & 32'h9, 32'h1);
   endtask : test_startup
   task automatic test_no_crystal;
      for (int m = 3; m <= 4; m++) begin
         sleep_wake(3'(m));
         repeat (150) @(posedge pclk);
         check(32'(sel_ext), 32'h0);
         apb(1'b0, STAT, 32'h0);
         check(rd & 32'h9, 32'h0);
      end
   endtask : test_no_crystal
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      test_registers_and_multiplier();
      test_startup(1'b0);
      test_startup(1'b1);
      test_no_crystal();
      report_and_stop();
   end
endmodule : osc_startup_test
`default_nettype wire

// ### tb/xtal_model.sv
`timescale 1ns/1ps
`default_nettype none
module xtal_model #(
   parameter int HALF = 5
) (
   input wire logic pclk,
   input wire logic run,
   output logic     osc_out
);
   int   cnt = 0;
   logic q   = 1'b0;
   assign osc_out = q;
   // a stopped crystal gives no edges, the pin rests low
   always @(posedge pclk) begin
      if (!run) begin
         cnt <= 0;
         q <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         q <= ~q;
      end else cnt <= cnt + 1;
   end
endmodule : xtal_model
`default_nettype wire
